// >>> rtl/spc_serial_ctrl.sv
`timescale 1ns/1ns
// Functional notes
// [R1] Control register clears to zero on reset, module standby and standby.
// [R2] Software may read and write the control register at any time.
// [R3] Bit 2 is reserved, reads zero, writes ignored.
// [R4] Bit 7 gates the transmit request raised when the empty flag sets.
// [R5] Transmit request drops on refill, read-one-write-zero, or enable cleared.
// [R6] Bit 6 gates receive, fault and break requests together.
// [R7] Receive requests drop on read-one-write-zero of the cause or enable cleared.
// [R8] Software drains the receive FIFO below trigger before clearing full flag.
// [R9] Bit 5 enables transmit; while off idle flag is one, empty flag cleared.
// [R10] With transmit on, sending starts as soon as the FIFO holds data.
// [R11] Software sets mode and FIFO control before enabling transmit.
// [R12] Clearing receive enable leaves all receive status flags as they were.
// [R13] Reception starts on a start bit, or on incoming clock in sync mode.
// [R14] Software sets the reception format before enabling receive.
// [R15] Bit 3 only acts in async multi-node format, ignored otherwise.
// [R16] While waiting, frames are dropped and receive flags and requests held off; the code still sets the break and leftover flags.
// [R17] A frame with node bit one sets the node flag and ends the wait.
// [R18] Bits 1 and 0 choose internal or external clock and the clock output.
// [R19] Each request is a level: enable and cause both set.
module spc_serial_ctrl import spc_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_standby,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  input wire logic i_tx_word_moved,
  input wire logic i_tx_at_or_below_trig,
  input wire logic i_tx_above_trig,
  input wire logic i_tx_fifo_nonempty,
  input wire logic i_tx_shift_idle,
  input wire logic i_rx_start_bit,
  input wire logic i_rx_frame_done,
  input wire logic i_rx_mpb,
  input wire logic i_rx_frame_err,
  input wire logic i_rx_parity_err,
  input wire logic i_rx_overrun_err,
  input wire logic i_rx_break,
  input wire logic i_rx_leftover,
  input wire logic i_rx_at_or_above_trig,
  input wire logic i_sck_pin,
  output logic o_sck_pin,
  output logic o_sck_pin_oe,
  output logic o_link_tick,
  output logic o_tx_fifo_irq,
  output logic o_rx_fifo_irq,
  output logic o_rx_fault_irq,
  output logic o_line_break_irq,
  output logic o_irq,
  output logic o_tx_go,
  output logic o_rx_active,
  output logic o_rx_store
);
  logic clr_all, wr_ctrl, wr_mode, wr_s1, wr_s2, rd_s1, rd_s2;
  logic tx_on, rx_on, mp_valid, wait_act, frame, accept, mp_hit;
  logic ext_edge, sck_drive, rx_err;
  logic [7:0] ctrl_q, mode_q, sts1_q, armed1_q, s1_set, s1_clr, rd_d;
  logic [1:0] sts2_q, armed2_q, s2_clr;
  logic [IRQ_W-1:0] req, req_q, irq_sts_q, irq_mask_q;

  // Standby acts exactly like reset on every piece of state here.
  assign clr_all = i_reset || i_standby; // R1
  assign wr_ctrl = i_wr_en && (i_addr == A_CTRL);
  assign wr_mode = i_wr_en && (i_addr == A_MODE);
  assign wr_s1 = i_wr_en && (i_addr == A_STS1);
  assign wr_s2 = i_wr_en && (i_addr == A_STS2);
  assign rd_s1 = i_rd_en && (i_addr == A_STS1);
  assign rd_s2 = i_rd_en && (i_addr == A_STS2);
  assign tx_on = ctrl_q[B_TE];
  assign rx_on = ctrl_q[B_RE];

  assign mp_valid = mode_q[M_MP] && !mode_q[M_SYNC] && !mode_q[M_IRDA]; // R15
  assign wait_act = ctrl_q[B_MULTI_NODE_WAIT_EN] && mp_valid; // R15
  assign frame = i_rx_frame_done && rx_on;
  assign accept = frame && (!wait_act || i_rx_mpb); // R16
  assign mp_hit = frame && wait_act && i_rx_mpb; // R17
  assign rx_err = i_rx_frame_err || i_rx_parity_err || i_rx_overrun_err;

  // The wait bit is cleared by hardware; a same-cycle software write wins.
  always_ff @(posedge i_sys_clk) begin
    if (clr_all) begin
      ctrl_q <= CTRL_RESET; // R1
    end else if (wr_ctrl) begin
      ctrl_q <= i_wr_data & CTRL_WMASK; // R2 R3
    end else if (mp_hit) begin
      ctrl_q[B_MULTI_NODE_WAIT_EN] <= 1'b0; // R17
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (clr_all) begin
      mode_q <= MODE_RESET;
    end else if (wr_mode) begin
      mode_q <= i_wr_data & MODE_WMASK;
    end
  end

  // Flags set by hardware win over a clear in the same cycle.
  always_comb begin
    s1_set = '0;
    s1_set[S_ER] = accept && rx_err; // R16
    s1_set[S_TEND] = !tx_on || i_tx_shift_idle; // R9
    s1_set[S_TX_FIFO_EMPTY_FLAG] = tx_on && i_tx_word_moved && i_tx_at_or_below_trig; // R4
    s1_set[S_BRK] = rx_on && i_rx_break;
    s1_set[S_FER] = accept && i_rx_frame_err; // R16
    s1_set[S_PER] = accept && i_rx_parity_err;
    s1_set[S_RDF] = accept && i_rx_at_or_above_trig; // R16
    s1_set[S_DR] = rx_on && i_rx_leftover;
  end

  // Clears never look at the receive enable, so receive flags survive it.
  always_comb begin
    s1_clr = wr_s1 ? (~i_wr_data & armed1_q & STS1_W0C) : 8'h00; // R5 R7 R12
    s1_clr[S_TEND] = 1'b1;
    s1_clr[S_TX_FIFO_EMPTY_FLAG] = s1_clr[S_TX_FIFO_EMPTY_FLAG] || i_tx_above_trig; // R5
    s1_clr[S_FER] = s1_clr[S_ER];
    s1_clr[S_PER] = s1_clr[S_ER];
    s2_clr = '0;
    s2_clr[S2_RX_OVERRUN] = wr_s2 && !i_wr_data[S2_RX_OVERRUN] && armed2_q[S2_RX_OVERRUN]; // R7
  end

  always_ff @(posedge i_sys_clk) begin
    if (clr_all) begin
      sts1_q <= STS1_RESET;
    end else if (!tx_on) begin
      sts1_q <= (sts1_q & ~s1_clr & ~(8'h01 << S_TX_FIFO_EMPTY_FLAG)) | s1_set; // R9
    end else begin
      sts1_q <= (sts1_q & ~s1_clr) | s1_set;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (clr_all) begin
      sts2_q <= '0;
    end else begin
      sts2_q[S2_RX_OVERRUN] <= (sts2_q[S2_RX_OVERRUN] && !s2_clr[S2_RX_OVERRUN]) || (accept && i_rx_overrun_err);
      if (frame && mp_valid) begin
        sts2_q[S2_MPB] <= i_rx_mpb; // R17
      end
    end
  end

  // A flag may only be cleared by a software write after software has seen it as one.
  always_ff @(posedge i_sys_clk) begin
    if (clr_all) begin
      armed1_q <= '0;
      armed2_q <= '0;
    end else begin
      if (rd_s1) begin
        armed1_q <= sts1_q; // R5 R7
      end else if (wr_s1) begin
        armed1_q <= '0;
      end
      if (rd_s2) begin
        armed2_q <= sts2_q;
      end else if (wr_s2) begin
        armed2_q <= '0;
      end
    end
  end

  always_comb begin
    req = '0;
    req[I_TX] = ctrl_q[B_TIE] && sts1_q[S_TX_FIFO_EMPTY_FLAG]; // R4 R19
    req[I_RX] = ctrl_q[B_RIE] && (sts1_q[S_RDF] || sts1_q[S_DR]); // R6 R19
    req[I_ERR] = ctrl_q[B_RIE] && (sts1_q[S_ER] || sts2_q[S2_RX_OVERRUN]); // R6
    req[I_BRK] = ctrl_q[B_RIE] && sts1_q[S_BRK]; // R6
  end

  always_ff @(posedge i_sys_clk) begin
    if (clr_all) begin
      req_q <= '0;
    end else begin
      req_q <= req; // R19
    end
  end

  assign o_tx_fifo_irq = req_q[I_TX];
  assign o_rx_fifo_irq = req_q[I_RX];
  assign o_rx_fault_irq = req_q[I_ERR];
  assign o_line_break_irq = req_q[I_BRK];

  // Sticky events catch each request rising; write one to clear.
  always_ff @(posedge i_sys_clk) begin
    if (clr_all) begin
      irq_sts_q <= '0;
      irq_mask_q <= '0;
      o_irq <= 1'b0;
    end else begin
      if (i_wr_en && (i_addr == A_IRQ_STS)) begin
        irq_sts_q <= (irq_sts_q & ~i_wr_data[IRQ_W-1:0]) | (req & ~req_q);
      end else begin
        irq_sts_q <= irq_sts_q | (req & ~req_q);
      end
      if (i_wr_en && (i_addr == A_IRQ_MASK)) begin
        irq_mask_q <= i_wr_data[IRQ_W-1:0];
      end
      o_irq <= |(irq_sts_q & irq_mask_q);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (clr_all) begin
      o_tx_go <= 1'b0;
      o_rx_store <= 1'b0;
      o_rx_active <= 1'b0;
    end else begin
      o_tx_go <= tx_on && i_tx_fifo_nonempty; // R10
      o_rx_store <= accept; // R16
      if (!rx_on || frame) begin
        o_rx_active <= 1'b0;
      end else if (mode_q[M_SYNC] ? ext_edge : i_rx_start_bit) begin
        o_rx_active <= 1'b1; // R13
      end
    end
  end

  always_comb begin
    rd_d = 8'h00;
    if (i_addr == A_CTRL) begin
      rd_d = ctrl_q; // R2 R3
    end else if (i_addr == A_MODE) begin
      rd_d = mode_q;
    end else if (i_addr == A_STS1) begin
      rd_d = sts1_q;
    end else if (i_addr == A_STS2) begin
      rd_d = {6'h00, sts2_q};
    end else if (i_addr == A_IRQ_STS) begin
      rd_d = {4'h0, irq_sts_q};
    end else if (i_addr == A_IRQ_MASK) begin
      rd_d = {4'h0, irq_mask_q};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (clr_all) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= i_rd_en ? rd_d : 8'h00;
    end
  end

  // Sync mode drives the clock whenever internal; async only when asked.
  assign sck_drive = !ctrl_q[B_CLK_SOURCE_SEL] && (mode_q[M_SYNC] || ctrl_q[B_CLK_OUT_EN]); // R18

  spc_sck_port u_sck (
    .i_sys_clk(i_sys_clk),
    .i_reset(clr_all),
    .i_sck_pin(i_sck_pin),
    .i_int_clk(!ctrl_q[B_CLK_SOURCE_SEL]),
    .i_drive(sck_drive),
    .i_ratio(mode_q[M_RATIO +: 2]),
    .o_sck_pin(o_sck_pin),
    .o_sck_pin_oe(o_sck_pin_oe),
    .o_ext_edge(ext_edge),
    .o_tick(o_link_tick)
  );

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  property p_standby_clear;
    i_standby |=> (ctrl_q == CTRL_RESET) && !o_tx_fifo_irq;
  endproperty
  a_standby_clear: assert property (p_standby_clear) else $error("standby left control set"); // R1

  property p_ctrl_write;
    (wr_ctrl && !i_standby) |=> (ctrl_q == ($past(i_wr_data) & CTRL_WMASK));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // R2

  property p_rsvd_zero;
    (i_rd_en && (i_addr == A_CTRL)) |=> !o_rd_data[B_RSVD];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read as one"); // R3

  property p_tx_req;
    (ctrl_q[B_TIE] && sts1_q[S_TX_FIFO_EMPTY_FLAG] && !i_standby) |=> o_tx_fifo_irq;
  endproperty
  a_tx_req: assert property (p_tx_req) else $error("transmit request missing"); // R4

  property p_tx_gate;
    !ctrl_q[B_TIE] |=> !o_tx_fifo_irq;
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("transmit request not gated"); // R5

  property p_rx_req;
    (ctrl_q[B_RIE] && (sts1_q[S_RDF] || sts1_q[S_DR]) && !i_standby) |=> o_rx_fifo_irq;
  endproperty
  a_rx_req: assert property (p_rx_req) else $error("receive request missing"); // R6

  property p_tx_off;
    (!tx_on && !i_standby) |=> !sts1_q[S_TX_FIFO_EMPTY_FLAG] && sts1_q[S_TEND];
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("flags wrong with transmit off"); // R9

  property p_wait_drop;
    (wait_act && frame && !i_rx_mpb && !i_standby) |=> !o_rx_store && !$rose(sts1_q[S_RDF]);
  endproperty
  a_wait_drop: assert property (p_wait_drop) else $error("frame taken while waiting"); // R16

  property p_mp_hit;
    (mp_hit && !wr_ctrl && !i_standby) |=> !ctrl_q[B_MULTI_NODE_WAIT_EN] && sts2_q[S2_MPB] && o_rx_store;
  endproperty
  a_mp_hit: assert property (p_mp_hit) else $error("node frame not handled"); // R17

  c_tx_req: cover property (o_tx_fifo_irq ##1 !o_tx_fifo_irq);
  c_mp_hit: cover property (wait_act ##[1:50] mp_hit);
  c_irq: cover property (o_irq && o_rx_fault_irq);
endmodule // spc_serial_ctrl

// >>> common/spc_pkg.sv
package spc_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] A_CTRL = 3'h0;
  localparam logic [2:0] A_MODE = 3'h1;
  localparam logic [2:0] A_STS1 = 3'h2;
  localparam logic [2:0] A_STS2 = 3'h3;
  localparam logic [2:0] A_IRQ_STS = 3'h4;
  localparam logic [2:0] A_IRQ_MASK = 3'h5;
  localparam int B_TIE = 7;
  localparam int B_RIE = 6;
  localparam int B_TE = 5;
  localparam int B_RE = 4;
  localparam int B_MULTI_NODE_WAIT_EN = 3;
  localparam int B_RSVD = 2;
  localparam int B_CLK_SOURCE_SEL = 1;
  localparam int B_CLK_OUT_EN = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hFB;
  localparam int M_SYNC = 7;
  localparam int M_IRDA = 6;
  localparam int M_MP = 2;
  localparam int M_RATIO = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'hC7;
  localparam int S_ER = 7;
  localparam int S_TEND = 6;
  localparam int S_TX_FIFO_EMPTY_FLAG = 5;
  localparam int S_BRK = 4;
  localparam int S_FER = 3;
  localparam int S_PER = 2;
  localparam int S_RDF = 1;
  localparam int S_DR = 0;
  localparam logic [7:0] STS1_RESET = 8'h40;
  localparam logic [7:0] STS1_W0C = 8'hB3;
  localparam int S2_MPB = 1;
  localparam int S2_RX_OVERRUN = 0;
  localparam int IRQ_W = 4;
  localparam int I_TX = 0;
  localparam int I_RX = 1;
  localparam int I_ERR = 2;
  localparam int I_BRK = 3;
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int BIT_RATE_HZ = 31_250;
  localparam int OVS_MAX = 16;
  localparam int HALF_CYC = SYS_CLK_HZ / (BIT_RATE_HZ * OVS_MAX * 2);
  localparam int CNT_W = 8;
endpackage

// >>> rtl/spc_sck_port.sv
`timescale 1ns/1ns
module spc_sck_port import spc_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_sck_pin,
  input wire logic i_int_clk,
  input wire logic i_drive,
  input wire logic [1:0] i_ratio,
  output logic o_sck_pin,
  output logic o_sck_pin_oe,
  output logic o_ext_edge,
  output logic o_tick
);
  logic s1_q, s2_q, s3_q, sck_q, wrap;
  logic [CNT_W-1:0] cnt_q, half;
  logic [1:0] sh;

  // Ratio codes above the 4x setting fall back to 4x.
  assign sh = (i_ratio > 2'h2) ? 2'h2 : i_ratio;
  assign half = CNT_W'(HALF_CYC) << sh;
  assign wrap = (cnt_q >= half - CNT_W'(1));

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= i_sck_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !i_int_clk) begin
      cnt_q <= '0;
      sck_q <= 1'b0;
    end else if (wrap) begin
      cnt_q <= '0;
      sck_q <= !sck_q;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_sck_pin <= 1'b0;
      o_sck_pin_oe <= 1'b0;
      o_ext_edge <= 1'b0;
      o_tick <= 1'b0;
    end else begin
      o_sck_pin <= sck_q;
      o_sck_pin_oe <= i_drive; // R18
      o_ext_edge <= !i_int_clk && s2_q && !s3_q; // R18
      o_tick <= i_int_clk ? (wrap && !sck_q) : (s2_q && !s3_q);
    end
  end
endmodule // spc_sck_port

// >>> test/spc_remote_station.sv
`timescale 1ns/1ns
module spc_remote_station (
  input wire logic i_sys_clk,
  output logic o_start_bit,
  output logic o_frame_done,
  output logic o_mpb,
  output logic o_frame_err,
  output logic o_parity_err,
  output logic o_overrun_err,
  output logic o_break,
  output logic o_sck
);
  initial begin
    o_start_bit = 1'b0;
    o_frame_done = 1'b0;
    {o_mpb, o_frame_err, o_parity_err, o_overrun_err, o_break} = 5'h0;
    o_sck = 1'b0;
  end
  // The link clock stands low between frames and is unrelated in phase to the bench clock.
  task automatic send_frame(input logic [4:0] q);
    int i;
    @(posedge i_sys_clk) o_start_bit <= 1'b1;
    @(posedge i_sys_clk) o_start_bit <= 1'b0;
    for (i = 0; i < 4; i++) begin
      #413 o_sck = 1'b1;
      #387 o_sck = 1'b0;
    end
    @(posedge i_sys_clk) begin
      {o_mpb, o_frame_err, o_parity_err, o_overrun_err, o_break} <= q;
      o_frame_done <= 1'b1;
    end
    // Qualifiers are only meaningful with the frame pulse, so afterwards they are driven inverted on purpose and break low.
    @(posedge i_sys_clk) begin
      o_frame_done <= 1'b0;
      {o_mpb, o_frame_err, o_parity_err, o_overrun_err} <= ~q[4:1];
      o_break <= 1'b0;
    end
  endtask
endmodule // spc_remote_station

// >>> test/spc_serial_ctrl_tb.sv
`timescale 1ns/1ns
module spc_serial_ctrl_tb import spc_pkg::*; ;
  logic clk = 1'b0, rst = 1'b1, stby = 1'b0, wen = 1'b0, ren = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wd = 8'h00, rdv, rdata, v;
  logic moved = 1'b0, below = 1'b0, above = 1'b0, nonempty = 1'b0, rx_trig = 1'b0;
  logic idle = 1'b1, left = 1'b0;
  logic start, done, multi_node_bit_in, ferr, perr, oerr, line_break_flag, sck, sck_prev = 1'b0;
  logic sck_o, sck_oe, tick, tx_fifo_irq, rx_fifo_irq, rx_fault_irq, line_break_irq, irq, go, rxa, store;
  int mismatches = 0, n_compared = 0, i, t0, s0, a0, ntick = 0, nsck = 0, nact = 0;
  always #50 clk = ~clk;
  // Running counts let a scenario measure the clock output and activity over a window.
  always @(posedge clk) begin
    if (rxa === 1'b1) nact <= nact + 1;
    if (tick === 1'b1) ntick <= ntick + 1;
    if (sck_o === 1'b1 && sck_prev !== 1'b1) nsck <= nsck + 1;
    sck_prev <= sck_o;
  end
  spc_remote_station i_spc_remote_station (.i_sys_clk(clk), .o_start_bit(start),
    .o_frame_done(done), .o_mpb(multi_node_bit_in), .o_frame_err(ferr), .o_parity_err(perr),
    .o_overrun_err(oerr), .o_break(line_break_flag), .o_sck(sck));
  spc_serial_ctrl i_spc_serial_ctrl (.i_sys_clk(clk), .i_reset(rst), .i_standby(stby),
    .i_addr(addr), .i_wr_data(wd), .i_wr_en(wen), .i_rd_en(ren), .o_rd_data(rdata),
    .i_tx_word_moved(moved), .i_tx_at_or_below_trig(below), .i_tx_above_trig(above),
    .i_tx_fifo_nonempty(nonempty), .i_tx_shift_idle(idle), .i_rx_start_bit(start),
    .i_rx_frame_done(done), .i_rx_mpb(multi_node_bit_in), .i_rx_frame_err(ferr),
    .i_rx_parity_err(perr), .i_rx_overrun_err(oerr), .i_rx_break(line_break_flag),
    .i_rx_leftover(left), .i_rx_at_or_above_trig(rx_trig), .i_sck_pin(sck),
    .o_sck_pin(sck_o), .o_sck_pin_oe(sck_oe), .o_link_tick(tick), .o_tx_fifo_irq(tx_fifo_irq),
    .o_rx_fifo_irq(rx_fifo_irq), .o_rx_fault_irq(rx_fault_irq), .o_line_break_irq(line_break_irq), .o_irq(irq),
    .o_tx_go(go), .o_rx_active(rxa), .o_rx_store(store));
  function automatic logic [7:0] rb(input logic [7:0] d, input logic [7:0] m);
    return d & m;
  endfunction
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) begin addr <= a; wd <= d; wen <= 1'b1; end
    @(posedge clk) wen <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk) begin addr <= a; ren <= 1'b1; end
    @(posedge clk) ren <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("mismatches=%0d compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #3000000 mismatches++;
    end_of_test;
  end
  initial begin
    void'($urandom(25));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(A_CTRL, rdv); chk(rdv, 8'h00);
    rd(A_STS1, rdv); chk(rdv, STS1_RESET);
    for (i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      wr(A_CTRL, v);
      rd(A_CTRL, rdv); chk(rdv, rb(v, 8'hFB));
    end
    rd(3'h7, rdv); chk(rdv, 8'h00);
    @(posedge clk) stby <= 1'b1;
    @(posedge clk) stby <= 1'b0;
    rd(A_CTRL, rdv); chk(rdv, 8'h00);
    // Software sets the format before enabling either direction.
    wr(A_MODE, 8'h00);
    wr(A_IRQ_MASK, 8'h01);
    nonempty <= 1'b1;
    wr(A_CTRL, 8'hA0);
    cyc(2); chk(go, 1);
    @(posedge clk) idle <= 1'b0;
    rd(A_STS1, rdv); chk(rb(rdv, 8'h40), 8'h00);
    @(posedge clk) idle <= 1'b1;
    @(posedge clk) begin moved <= 1'b1; below <= 1'b1; end
    @(posedge clk) moved <= 1'b0;
    cyc(2); chk(tx_fifo_irq, 1);
    chk(irq, 1);
    rd(A_STS1, rdv); chk(rb(rdv, 8'h20), 8'h20);
    @(posedge clk) begin above <= 1'b1; below <= 1'b0; end
    cyc(3); chk(tx_fifo_irq, 0);
    @(posedge clk) begin above <= 1'b0; below <= 1'b1; moved <= 1'b1; end
    @(posedge clk) moved <= 1'b0;
    cyc(2); chk(tx_fifo_irq, 1);
    rd(A_STS1, rdv);
    wr(A_STS1, rb(rdv, 8'hDF));
    cyc(2); chk(tx_fifo_irq, 0);
    @(posedge clk) moved <= 1'b1;
    @(posedge clk) moved <= 1'b0;
    cyc(2); chk(tx_fifo_irq, 1);
    wr(A_CTRL, 8'h20);
    cyc(2); chk(tx_fifo_irq, 0);
    wr(A_IRQ_MASK, 8'h00);
    cyc(2); chk(irq, 0);
    wr(A_IRQ_MASK, 8'h01);
    cyc(2); chk(irq, 1);
    wr(A_CTRL, 8'h00);
    rd(A_STS1, rdv); chk(rb(rdv, 8'h60), 8'h40);
    wr(A_IRQ_STS, 8'h01);
    cyc(2); chk(irq, 0);
    chk(go, 0);
    nonempty <= 1'b0;
    wr(A_CTRL, 8'h50);
    rx_trig <= 1'b1;
    i_spc_remote_station.send_frame(5'b00000);
    #1 chk(store, 1);
    cyc(2); chk(rx_fifo_irq, 1);
    chk(nact != 0, 1);
    i_spc_remote_station.send_frame(5'b01001);
    cyc(3); chk({rx_fault_irq, line_break_irq}, 2'b11);
    wr(A_CTRL, 8'h40);
    rd(A_STS1, rdv); chk(rb(rdv, 8'h9A), 8'h9A);
    // The receive FIFO is drained below trigger before the full flag is cleared.
    rx_trig <= 1'b0;
    rd(A_STS1, rdv);
    wr(A_STS1, rb(rdv, 8'hFD));
    cyc(2); chk({rx_fifo_irq, rx_fault_irq}, 2'b01);
    wr(A_CTRL, 8'h00);
    cyc(2); chk({rx_fault_irq, line_break_irq}, 2'b00);
    wr(A_CTRL, 8'h50);
    @(posedge clk) left <= 1'b1;
    @(posedge clk) left <= 1'b0;
    cyc(2); chk(rx_fifo_irq, 1);
    rd(A_STS1, rdv);
    wr(A_STS1, rb(rdv, 8'hFE));
    cyc(2); chk(rx_fifo_irq, 0);
    wr(A_MODE, 8'h04);
    wr(A_CTRL, 8'h58);
    rx_trig <= 1'b1;
    i_spc_remote_station.send_frame(5'b00000);
    #1 chk(store, 0);
    cyc(2); chk(rx_fifo_irq, 0);
    i_spc_remote_station.send_frame(5'b10000);
    #1 chk(store, 1);
    rd(A_CTRL, rdv); chk(rdv, 8'h50);
    rd(A_STS2, rdv); chk(rb(rdv, 8'h02), 8'h02);
    wr(A_MODE, 8'h84);
    wr(A_CTRL, 8'h5A);
    cyc(1);
    t0 = ntick;
    a0 = nact;
    i_spc_remote_station.send_frame(5'b00000);
    #1 chk(store, 1);
    chk(nact != a0, 1);
    chk(8'(ntick - t0), 8'h04);
    wr(A_MODE, 8'h44);
    wr(A_CTRL, 8'h58);
    i_spc_remote_station.send_frame(5'b00000);
    #1 chk(store, 1);
    wr(A_MODE, 8'h00);
    wr(A_CTRL, 8'h01);
    cyc(2); chk(sck_oe, 1);
    for (i = 0; i < 2; i++) begin
      wr(A_MODE, 8'(i));
      cyc(50);
      t0 = ntick;
      s0 = nsck;
      cyc(200);
      chk(8'(ntick - t0), 8'(200 / (2 * (HALF_CYC << i))));
      chk(8'(nsck - s0), 8'(200 / (2 * (HALF_CYC << i))));
    end
    wr(A_MODE, 8'h80);
    wr(A_CTRL, 8'h00);
    cyc(2); chk(sck_oe, 1);
    wr(A_CTRL, 8'h02);
    cyc(2); chk(sck_oe, 0);
    end_of_test;
  end
endmodule // spc_serial_ctrl_tb
